// ===== design/motor_regs_pkg.sv
package motor_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DEV_CTRL     = 8'h03;
  localparam logic [7:0] OFS_SPEED_HI     = 8'h11;
  localparam logic [7:0] OFS_SPEED_LO     = 8'h12;
  localparam logic [7:0] OFS_PERIOD_HI    = 8'h13;
  localparam logic [7:0] OFS_PERIOD_LO    = 8'h14;
  localparam logic [7:0] OFS_VCONST_HI    = 8'h15;
  localparam logic [7:0] OFS_VCONST_LO    = 8'h16;
  localparam logic [7:0] OFS_ROTOR_POS    = 8'h19;
  localparam logic [7:0] OFS_SUPPLY       = 8'h1a;
  localparam logic [7:0] OFS_RAW_CMD      = 8'h1b;
  localparam logic [7:0] OFS_SMOOTH_CMD   = 8'h1c;
  localparam logic [7:0] OFS_FAULT        = 8'h1e;
  localparam logic [7:0] OFS_PARAM_ONE    = 8'h20;
  localparam logic [7:0] OFS_PARAM_TWO    = 8'h21;
  localparam logic [7:0] OFS_PARAM_THREE  = 8'h22;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CFG_WE_BIT   = 6;
  localparam int         MODE_BIT     = 7;
  localparam int         EXP_MSB      = 6;
  localparam int         EXP_LSB      = 4;
  localparam int         MANT_MSB     = 3;
  localparam int         FAULT_W      = 6;
  localparam logic [7:0] PARAM_ONE_RST   = 8'h4a;
  localparam logic [7:0] PARAM_TWO_RST   = 8'h4e;
  localparam logic [7:0] PARAM_THREE_RST = 8'h2a;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PWM_LOW_KHZ    = 25;
  localparam int PWM_HIGH_KHZ   = 50;
  localparam int ADV_UNIT_NS    = 2500;
  localparam logic [15:0] PWM_LOW_CYCLES =
    16'(1_000_000 / (PWM_LOW_KHZ * CLK_PERIOD_NS));
  localparam logic [15:0] PWM_HIGH_CYCLES =
    16'(1_000_000 / (PWM_HIGH_KHZ * CLK_PERIOD_NS));
  localparam logic [8:0] ADV_UNIT_CYCLES = 9'(ADV_UNIT_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]        rotation_rate_reading;     // 0.1 Hz units
    logic [15:0]        electrical_period_reading; // 10 us units
    logic [14:0]        velocity_const_digital;    // digital phase constant
    logic [7:0]         rotor_angle_estimate;
    logic [7:0]         advance_angle;
    logic [7:0]         supply_level_code;
    logic [7:0]         raw_speed_command;
    logic [8:0]         smoothed_speed_command;
    logic [FAULT_W-1:0] fault_flags;
  } telemetry_t;

  typedef struct packed {
    logic        pwm_frequency_double;
    logic [15:0] pwm_period_cycles;
    logic [10:0] phase_resistance_value;
    logic        closed_loop_adjust_select;
    logic [10:0] velocity_constant_value;
    logic        advance_timing_select;
    logic [10:0] advance_delay_value;
    logic [19:0] advance_delay_cycles;
  } drive_cfg_t;

endpackage

// ===== design/motor_status_param_regs.sv
`timescale 1ns/1ps
module motor_status_param_regs
  import motor_regs_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h52
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Serial pins, open drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Core side
  input  wire telemetry_t telemetry,
  output drive_cfg_t      drive_cfg,
  output logic            config_write_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_ACK  = 3'b010,
    ST_WRITE     = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ      = 3'b101,
    ST_READ_ACK  = 3'b110
  } xfer_state_t;

  typedef struct packed {
    xfer_state_t     st;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      tx;
    logic            rw;
    logic            first;
    logic            nack;
    logic [7:0]      ptr;
    logic [2:0][7:0] shadow;
    logic            we;
    logic [7:0]      p1;
    logic [7:0]      p2;
    logic [7:0]      p3;
    logic [2:0]      scl_s;
    logic [2:0]      sda_s;
    logic            scl_f;
    logic            sda_f;
    logic            oe;
    logic            dout;
    drive_cfg_t      cfg;
  } state_t;

  state_t q;
  state_t d;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Mantissa shifted by exponent
  function automatic logic [10:0] mant_exp(input logic [7:0] r);
    mant_exp = 11'({7'h00, r[MANT_MSB:0]} << r[EXP_MSB:EXP_LSB]);
  endfunction

  // Index of the word pair an offset belongs to, 3 if none
  function automatic logic [1:0] pair_of(input logic [7:0] a);
    unique case (a)
      OFS_SPEED_HI, OFS_SPEED_LO:   pair_of = 2'd0;
      OFS_PERIOD_HI, OFS_PERIOD_LO: pair_of = 2'd1;
      OFS_VCONST_HI, OFS_VCONST_LO: pair_of = 2'd2;
      default:                      pair_of = 2'd3;
    endcase
  endfunction

  // Sixteen-bit reading of one pair
  function automatic logic [15:0] pair_word(input logic [1:0] i,
                                            input telemetry_t t);
    unique case (i)
      2'd0:    pair_word = t.rotation_rate_reading;
      2'd1:    pair_word = t.electrical_period_reading;
      2'd2:    pair_word = {t.velocity_const_digital, 1'b0};
      default: pair_word = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [7:0]  rd_data;
  logic [15:0] rd_word;
  logic [1:0]  rd_pair;
  logic        rd_high;

  always_comb begin
    rd_pair = pair_of(q.ptr);
    rd_high = (q.ptr == OFS_SPEED_HI) || (q.ptr == OFS_PERIOD_HI) ||
              (q.ptr == OFS_VCONST_HI);
    rd_word = pair_word(rd_pair, telemetry);
    rd_data = 8'h00;
    if (rd_pair != 2'd3) begin
      if (rd_high) begin
        rd_data = rd_word[15:8];
      end else begin
        rd_data = q.shadow[rd_pair];
      end
    end else begin
      unique case (q.ptr)
        OFS_DEV_CTRL:    rd_data = 8'(q.we) << CFG_WE_BIT;
        OFS_ROTOR_POS:   rd_data = 8'(telemetry.rotor_angle_estimate +
                                      telemetry.advance_angle);
        OFS_SUPPLY:      rd_data = telemetry.supply_level_code;
        OFS_RAW_CMD:     rd_data = telemetry.raw_speed_command;
        OFS_SMOOTH_CMD:  rd_data =
                           telemetry.smoothed_speed_command[8:1];
        OFS_FAULT:       rd_data = {2'b00, telemetry.fault_flags};
        OFS_PARAM_ONE:   rd_data = q.p1;
        OFS_PARAM_TWO:   rd_data = q.p2;
        OFS_PARAM_THREE: rd_data = q.p3;
        default:         rd_data = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic scl_n;
  logic sda_n;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic load_c;

  always_comb begin
    d = q;
    load_c = 1'b0;
    // Three-stage synchronisers, accept when stages two and three agree
    d.scl_s = {q.scl_s[1:0], scl_in};
    d.sda_s = {q.sda_s[1:0], sda_in};
    scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
    sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
    d.scl_f = scl_n;
    d.sda_f = sda_n;
    scl_rise = scl_n & ~q.scl_f;
    scl_fall = ~scl_n & q.scl_f;
    start_c = q.scl_f & scl_n & q.sda_f & ~sda_n;
    stop_c  = q.scl_f & scl_n & ~q.sda_f & sda_n;

    if (start_c) begin
      d.st  = ST_ADDR;
      d.cnt = 4'd0;
      d.oe  = 1'b0;
    end else if (stop_c) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          d.oe = 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], sda_n};
            d.cnt = 4'(q.cnt + 4'd1);
          end else if (scl_fall && q.cnt == 4'd8) begin
            d.cnt = 4'd0;
            if (q.st == ST_ADDR) begin
              if (q.sh[7:1] == TARGET_ADDR) begin
                d.st = ST_ADDR_ACK;
                d.rw = q.sh[0];
                d.oe = 1'b1;
              end else begin
                d.st = ST_IDLE;
              end
            end else begin
              d.st    = ST_WRITE_ACK;
              d.oe    = 1'b1;
              d.first = 1'b0;
              if (q.first) begin
                d.ptr = q.sh;
              end else begin
                d.ptr = 8'(q.ptr + 8'd1);
                // Only the control and parameter bytes are writable
                unique case (q.ptr)
                  OFS_DEV_CTRL:    d.we = q.sh[CFG_WE_BIT];
                  OFS_PARAM_ONE:   if (q.we) d.p1 = q.sh;
                  OFS_PARAM_TWO:   if (q.we) d.p2 = q.sh;
                  OFS_PARAM_THREE: if (q.we) d.p3 = q.sh;
                  default:         d.we = q.we;
                endcase
              end
            end
          end
        end
        ST_ADDR_ACK, ST_READ_ACK: begin
          if (scl_rise) begin
            d.nack = sda_n;
          end else if (scl_fall) begin
            if (q.st == ST_ADDR_ACK && !q.rw) begin
              d.st    = ST_WRITE;
              d.first = 1'b1;
              d.oe    = 1'b0;
            end else if (q.st == ST_READ_ACK && q.nack) begin
              d.st = ST_IDLE;
              d.oe = 1'b0;
            end else begin
              load_c = 1'b1;
              d.st   = ST_READ;
              d.cnt  = 4'd0;
              d.tx   = rd_data;
              d.oe   = ~rd_data[7];
              d.ptr  = 8'(q.ptr + 8'd1);
              if (rd_high) begin
                d.shadow[rd_pair] = rd_word[7:0];
              end
            end
          end
        end
        ST_WRITE_ACK: begin
          // Hold the acknowledge until the ninth clock falls
          if (scl_fall) begin
            d.st = ST_WRITE;
            d.oe = 1'b0;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (q.cnt == 4'd7) begin
              d.st = ST_READ_ACK;
              d.oe = 1'b0;
            end else begin
              d.tx  = {q.tx[6:0], 1'b0};
              d.cnt = 4'(q.cnt + 4'd1);
              d.oe  = ~q.tx[6];
            end
          end
        end
        default: begin
          d.st = ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end

    // Decoded drive configuration
    d.cfg.pwm_frequency_double = q.p1[MODE_BIT];
    d.cfg.pwm_period_cycles = q.p1[MODE_BIT] ? PWM_HIGH_CYCLES
                                             : PWM_LOW_CYCLES;
    d.cfg.phase_resistance_value    = mant_exp(q.p1);
    d.cfg.closed_loop_adjust_select = q.p2[MODE_BIT];
    d.cfg.velocity_constant_value   = mant_exp(q.p2);
    d.cfg.advance_timing_select     = q.p3[MODE_BIT];
    d.cfg.advance_delay_value       = mant_exp(q.p3);
    d.cfg.advance_delay_cycles =
      20'(mant_exp(q.p3) * ADV_UNIT_CYCLES);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.scl_s <= 3'b111;
      q.sda_s <= 3'b111;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.p1    <= PARAM_ONE_RST;
      q.p2    <= PARAM_TWO_RST;
      q.p3    <= PARAM_THREE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign sda_out             = q.dout;
  assign sda_oe              = q.oe;
  assign drive_cfg           = q.cfg;
  assign config_write_enable = q.we;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pwm_select_a: assert property (@(posedge clk) disable iff (srst)
    !srst |=> drive_cfg.pwm_period_cycles ==
      ($past(q.p1[MODE_BIT]) ? PWM_HIGH_CYCLES : PWM_LOW_CYCLES))
    else $error("pwm period does not follow frequency bit");

  res_decode_a: assert property (@(posedge clk) disable iff (srst)
    $past(!srst) |-> drive_cfg.phase_resistance_value ==
      11'({7'h00, $past(q.p1[3:0])} << $past(q.p1[6:4])))
    else $error("resistance decode wrong");

  adj_mode_a: assert property (@(posedge clk) disable iff (srst)
    $changed(q.p2[MODE_BIT]) |=>
      drive_cfg.closed_loop_adjust_select == $past(q.p2[MODE_BIT]))
    else $error("adjust mode not propagated");

  kt_decode_a: assert property (@(posedge clk) disable iff (srst)
    $past(!srst) |-> drive_cfg.velocity_constant_value ==
      11'({7'h00, $past(q.p2[3:0])} << $past(q.p2[6:4])))
    else $error("velocity constant decode wrong");

  adv_mode_a: assert property (@(posedge clk) disable iff (srst)
    $changed(q.p3[MODE_BIT]) |=>
      drive_cfg.advance_timing_select == $past(q.p3[MODE_BIT]))
    else $error("advance mode not propagated");

  adv_delay_a: assert property (@(posedge clk) disable iff (srst)
    $past(!srst) |-> drive_cfg.advance_delay_cycles ==
      20'(drive_cfg.advance_delay_value * 20'd250))
    else $error("advance delay scaling wrong");

  param_lock_a: assert property (@(posedge clk) disable iff (srst)
    !q.we |=> q.p1 == $past(q.p1) && q.p2 == $past(q.p2) &&
              q.p3 == $past(q.p3))
    else $error("parameter changed while writes disabled");

  low_latch_a: assert property (@(posedge clk) disable iff (srst)
    load_c && q.ptr == OFS_SPEED_HI |=>
      q.shadow[0] == $past(telemetry.rotation_rate_reading[7:0]))
    else $error("low speed byte not latched");

  fault_pad_a: assert property (@(posedge clk) disable iff (srst)
    load_c && q.ptr == OFS_FAULT |=> q.tx[7:6] == 2'b00)
    else $error("unused fault bits not zero");

  rotor_sum_a: assert property (@(posedge clk) disable iff (srst)
    load_c && q.ptr == OFS_ROTOR_POS |=>
      q.tx == 8'($past(telemetry.rotor_angle_estimate) +
                 $past(telemetry.advance_angle)))
    else $error("rotor position lacks advance angle");

endmodule

// ===== tb/bus_host.sv
`timescale 1ns/1ps
// Controller on the serial bus: drives the clock, shares the data line
module bus_host (
  // Clock
  input  wire logic clk,
  // Target pull-down
  input  wire logic sda_oe,
  // Bus lines
  output logic      scl,
  output logic      sda
);
  localparam int PH = 8;
  logic scl_q = 1'b1;
  logic low_q = 1'b0;

  // ------------
  // Line levels
  // ------------
  // Pull-up holds the line high unless some party pulls it low
  assign sda = ~(low_q | sda_oe);
  assign scl = scl_q;

  // ------------
  // Bit level
  // ------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data set mid-low; line sampled just before clock falls
  task automatic slot(input logic v, output logic s);
    tick(PH / 2);
    low_q <= ~v;
    tick(PH / 2);
    scl_q <= 1'b1;
    tick(PH - 1);
    @(negedge clk);
    s = sda;
    @(posedge clk);
    scl_q <= 1'b0;
  endtask

  // Start or repeated start; releases the data line, then pulls it low while the clock is high
  task automatic start();
    tick(PH);
    low_q <= 1'b0;
    tick(PH / 2);
    scl_q <= 1'b1;
    tick(PH);
    low_q <= 1'b1;
    tick(PH);
    scl_q <= 1'b0;
  endtask

  task automatic stop();
    tick(PH / 2);
    low_q <= 1'b1;
    tick(PH / 2);
    scl_q <= 1'b1;
    tick(PH);
    low_q <= 1'b0;
    tick(PH);
  endtask

  // ------------
  // Byte level
  // ------------
  // Byte out, MSB first; ack high when the target pulled low
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask

  // Byte in, MSB first; last byte answered with a NACK
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(last, s);
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import motor_regs_pkg::*;
  localparam logic [6:0] ADDR = 7'h52;
  logic       clk;
  logic       srst;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic       sda_o;
  logic       cwe;
  telemetry_t tel;
  drive_cfg_t cfg;
  logic [7:0] rb [0:15];
  int         err_count = 0;
  int         compares = 0;
  int         cyc = 0;

  // ------------
  // Instances
  // ------------
  motor_status_param_regs #(.TARGET_ADDR(ADDR)) u_motor_status_param_regs (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe(sda_oe), .telemetry(tel), .drive_cfg(cfg),
    .config_write_enable(cwe));
  bus_host u_bus_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // ------------
  // Reporting
  // ------------
  task automatic test_done();
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t bit got %b exp %b", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk20(input logic [19:0] g, input logic [19:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t field got %0d exp %0d", $time, g, e);
    end
  endtask

  // ------------
  // Transfers
  // ------------
  task automatic tx(input logic [7:0] b);
    logic a;
    u_bus_host.put(b, a);
    chk1(a, 1'b1);
  endtask

  // Writes n bytes, first from d[23:16]
  task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n);
    u_bus_host.start();
    tx({ADDR, 1'b0});
    tx(p);
    for (int i = 0; i < n; i++) tx(d[23 - 8 * i -: 8]);
    u_bus_host.stop();
  endtask

  task automatic rd(input logic [7:0] p, input int n);
    u_bus_host.start();
    tx({ADDR, 1'b0});
    tx(p);
    u_bus_host.start();
    tx({ADDR, 1'b1});
    for (int i = 0; i < n; i++) u_bus_host.get(i == n - 1, rb[i]);
    u_bus_host.stop();
  endtask

  // Parameter bytes read back and decoded outputs
  task automatic chk_par(input logic [7:0] p1, p2, p3);
    rd(8'h20, 3);
    chk8(rb[0], p1);
    chk8(rb[1], p2);
    chk8(rb[2], p3);
    chk1(cfg.pwm_frequency_double, p1[7]);
    chk20(20'(cfg.pwm_period_cycles), p1[7] ? 20'd2000 : 20'd4000);
    chk20(20'(cfg.phase_resistance_value), 20'(p1[3:0]) << p1[6:4]);
    chk1(cfg.closed_loop_adjust_select, p2[7]);
    chk20(20'(cfg.velocity_constant_value), 20'(p2[3:0]) << p2[6:4]);
    chk1(cfg.advance_timing_select, p3[7]);
    chk20(20'(cfg.advance_delay_value), 20'(p3[3:0]) << p3[6:4]);
    chk20(cfg.advance_delay_cycles, (20'(p3[3:0]) << p3[6:4]) * 250);
  endtask

  // ------------
  // Scenarios
  // ------------
  task automatic t_locked();
    chk1(cwe, 1'b0);
    wr(8'h20, 24'h970000, 1);
    chk_par(8'h4a, 8'h4e, 8'h2a);
  endtask

  task automatic t_unlock();
    wr(8'h03, 24'h400000, 1);
    chk1(cwe, 1'b1);
    wr(8'h20, 24'h97f3c5, 3);
    chk_par(8'h97, 8'hf3, 8'hc5);
    wr(8'h20, 24'h0f7f70, 3);
    chk_par(8'h0f, 8'h7f, 8'h70);
  endtask

  task automatic t_telem();
    rd(8'h11, 14);
    chk8(rb[0], 8'h01);
    chk8(rb[1], 8'hff);
    chk8(rb[2], 8'h2a);
    chk8(rb[3], 8'h3c);
    chk8(rb[4], 8'h86);
    chk8(rb[5], 8'h42);
    chk8(rb[6], 8'h00);
    chk8(rb[8], 8'h20);
    chk8(rb[9], 8'h87);
    chk8(rb[10], 8'hff);
    chk8(rb[11], 8'hd2);
    chk8(rb[13], 8'h2b);
  endtask

  task automatic t_coherent();
    rd(8'h11, 1);
    chk8(rb[0], 8'h01);
    @(posedge clk) tel.rotation_rate_reading <= 16'h0234;
    rd(8'h12, 1);
    chk8(rb[0], 8'hff);
    rd(8'h11, 2);
    chk8(rb[0], 8'h02);
    chk8(rb[1], 8'h34);
  endtask

  task automatic t_ro_write();
    wr(8'h1b, 24'h000000, 3);
    wr(8'h1e, 24'h000000, 1);
    rd(8'h1b, 4);
    chk8(rb[0], 8'hff);
    chk8(rb[1], 8'hd2);
    chk8(rb[3], 8'h2b);
  endtask

  task automatic t_bad_addr();
    logic a;
    u_bus_host.start();
    u_bus_host.put({ADDR ^ 7'h01, 1'b0}, a);
    chk1(a, 1'b0);
    chk1(sda_o, 1'b0);
    u_bus_host.stop();
  endtask

  // ------------
  // Clock, sequence, watchdog
  // ------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    srst <= 1'b1;
    tel <= '{16'h01ff, 16'h2a3c, 15'h4321, 8'hf0, 8'h30, 8'h87, 8'hff,
             9'h1a5, 6'h2b};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_locked();
    t_unlock();
    t_telem();
    t_coherent();
    t_ro_write();
    t_bad_addr();
    test_done();
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
endmodule
